// *** core/arrow_entry_pkg.sv ***
// shared constants for the arrow-switch digit entry unit
package arrow_entry_pkg;
	// switch input offsets
	localparam int SW_INC = 0;
	localparam int SW_DEC = 1;
	localparam int SW_DOWN = 2;
	localparam int SW_UP = 3;
	localparam int NUM_SW = 4;
	// display output layout: data in 3..0, strobes in 7..4
	localparam int DATA_LSB = 0;
	localparam int STROBE_LSB = 4;
	localparam int NUM_DISP = 8;
	localparam int NUM_DIGITS = 4;
	localparam logic [15:0] VALUE_MAX = 16'h270F;
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam logic [1:0] POL_RESET = 2'h0;
	// digit index: 0 thousands, 1 hundreds, 2 tens, 3 units
	localparam logic [1:0] SEL_THOUSANDS = 2'h0;
	localparam logic [1:0] SEL_UNITS = 2'h3;
	localparam logic [1:0] POL_MAX = 2'h3;
	// step through the four digits on the display, one system clock each
	localparam int SCAN_CYCLES = 1;
endpackage : arrow_entry_pkg

// *** core/arrow_switch_digit_entry.sv ***
// four-digit decimal entry unit driven by four arrow switches
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// What this block does
// ****************************************************************
module arrow_switch_digit_entry #(
	parameter logic [1:0] POLARITY = 2'h1
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_cmd_enable,
	input wire logic [3:0] i_switches,
	output logic [15:0] o_entered_value_word,
	output logic [7:0] o_display_outputs,
	output logic [1:0] o_selected_digit,
	output logic o_execution_state_out
);
	// ****************************************************************
	// parameter check
	// ****************************************************************
	// only single-set codes exist here; the two-set range 4..7 cannot be typed
	initial begin
		if (POLARITY > arrow_entry_pkg::POL_MAX) begin
			$error("polarity parameter out of range");
		end
	end

	// ****************************************************************
	// switch inputs
	// ****************************************************************
	logic [3:0] press;
	logic run;
	assign run = i_ce && i_cmd_enable;

	switch_sync #(
		.WIDTH(arrow_entry_pkg::NUM_SW)
	) u_sync (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_raw(i_switches),
		.o_level(),
		.o_press(press)
	);

	logic inc_p;
	logic dec_p;
	logic down_p;
	logic up_p;
	assign inc_p = press[arrow_entry_pkg::SW_INC];
	assign dec_p = press[arrow_entry_pkg::SW_DEC];
	assign down_p = press[arrow_entry_pkg::SW_DOWN];
	assign up_p = press[arrow_entry_pkg::SW_UP];

	// ****************************************************************
	// digit selection
	// ****************************************************************
	logic [1:0] sel_ff;
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sel_ff <= arrow_entry_pkg::SEL_THOUSANDS;
		end else if (run) begin
			if (down_p && !up_p) begin
				sel_ff <= sel_ff + 2'h1;
			end else if (up_p && !down_p) begin
				sel_ff <= sel_ff - 2'h1;
			end
		end
	end

	// ****************************************************************
	// value storage and digit edit
	// ****************************************************************
	logic [3:0] dig_th;
	logic [3:0] dig_hu;
	logic [3:0] dig_te;
	logic [3:0] dig_un;
	logic [15:0] value_ff;
	logic [15:0] nxt_value;
	logic [3:0] cur_digit;
	logic [3:0] new_digit;
	logic [15:0] weight;

	// binary to decimal digits; value is bounded so the divides stay small
	always_comb begin
		dig_th = 4'((value_ff / 16'h03E8) % 16'h000A);
		dig_hu = 4'((value_ff / 16'h0064) % 16'h000A);
		dig_te = 4'((value_ff / 16'h000A) % 16'h000A);
		dig_un = 4'(value_ff % 16'h000A);
	end

	always_comb begin
		unique case (sel_ff)
			2'h0: begin
				cur_digit = dig_th;
				weight = 16'h03E8;
			end
			2'h1: begin
				cur_digit = dig_hu;
				weight = 16'h0064;
			end
			2'h2: begin
				cur_digit = dig_te;
				weight = 16'h000A;
			end
			2'h3: begin
				cur_digit = dig_un;
				weight = 16'h0001;
			end
		endcase
	end

	always_comb begin
		new_digit = cur_digit;
		if (inc_p && !dec_p) begin
			new_digit = (cur_digit == arrow_entry_pkg::DIGIT_MAX) ? 4'h0 : cur_digit + 4'h1;
		end else if (dec_p && !inc_p) begin
			new_digit = (cur_digit == 4'h0) ? arrow_entry_pkg::DIGIT_MAX : cur_digit - 4'h1;
		end
		// swap only the selected digit's contribution
		nxt_value = 16'(value_ff - 16'(cur_digit * weight) + 16'(new_digit * weight));
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			value_ff <= arrow_entry_pkg::VALUE_RESET;
		end else if (run) begin
			value_ff <= nxt_value;
		end
	end

	// ****************************************************************
	// display scan
	// ****************************************************************
	// the scan walks all four digits but only the selected digit is strobed, so a latching display refreshes that one alone
	logic [1:0] scan_ff;
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			scan_ff <= arrow_entry_pkg::SEL_THOUSANDS;
		end else if (run) begin
			scan_ff <= scan_ff + 2'h1;
		end else if (i_ce) begin
			// restart from the top once enable returns
			scan_ff <= arrow_entry_pkg::SEL_THOUSANDS;
		end
	end

	logic [3:0] scan_digit;
	always_comb begin
		unique case (scan_ff)
			2'h0: scan_digit = dig_th;
			2'h1: scan_digit = dig_hu;
			2'h2: scan_digit = dig_te;
			2'h3: scan_digit = dig_un;
		endcase
	end

	// idle levels of the display pins, also their value under reset
	localparam logic POL_RESET_STROBE = POLARITY[0];
	localparam logic POL_RESET_DATA = POLARITY[1];

	logic [7:0] disp_ff;
	logic [3:0] strobe_raw;
	logic data_inv;
	logic strobe_inv;
	assign data_inv = POLARITY[1];
	assign strobe_inv = POLARITY[0];

	// strobe index 4 is thousands, 7 is units; only the selected digit's strobe is high
	always_comb begin
		strobe_raw = 4'h0;
		if (scan_ff == sel_ff) begin
			strobe_raw[sel_ff] = 1'b1;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			disp_ff <= {{4{POL_RESET_STROBE}}, {4{POL_RESET_DATA}}};
		end else if (i_ce) begin
			if (run) begin
				disp_ff[7:4] <= strobe_raw ^ {4{strobe_inv}};
				disp_ff[3:0] <= scan_digit ^ {4{data_inv}};
			end else begin
				disp_ff <= {{4{strobe_inv}}, {4{data_inv}}};
			end
		end
	end

	logic eno_ff;
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			eno_ff <= 1'b0;
		end else if (i_ce) begin
			eno_ff <= i_cmd_enable;
		end
	end

	assign o_entered_value_word = value_ff;
	assign o_display_outputs = disp_ff;
	assign o_selected_digit = sel_ff;
	assign o_execution_state_out = eno_ff;

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_range;
		@(posedge i_clock) disable iff (i_rst)
		value_ff <= arrow_entry_pkg::VALUE_MAX;
	endproperty
	a_range: assert property (p_range) else $error("value above 9999");

	property p_hold_disabled;
		@(posedge i_clock) disable iff (i_rst)
		!i_cmd_enable |=> $stable(value_ff) && $stable(sel_ff);
	endproperty
	a_hold_disabled: assert property (p_hold_disabled) else $error("changed while off");

	property p_down_wrap;
		@(posedge i_clock) disable iff (i_rst)
		run && down_p && !up_p && sel_ff == arrow_entry_pkg::SEL_UNITS
			|=> sel_ff == arrow_entry_pkg::SEL_THOUSANDS;
	endproperty
	a_down_wrap: assert property (p_down_wrap) else $error("move down wrap wrong");

	property p_up_step;
		@(posedge i_clock) disable iff (i_rst)
		run && up_p && !down_p && sel_ff == arrow_entry_pkg::SEL_THOUSANDS
			|=> sel_ff == arrow_entry_pkg::SEL_UNITS;
	endproperty
	a_up_step: assert property (p_up_step) else $error("move up from thousands wrong");

	property p_inc_wrap;
		@(posedge i_clock) disable iff (i_rst)
		run && inc_p && !dec_p && cur_digit == 4'h9 |=> value_ff == $past(value_ff) - 16'(9 * $past(weight));
	endproperty
	a_inc_wrap: assert property (p_inc_wrap) else $error("increment wrap wrong");

	property p_dec_wrap;
		@(posedge i_clock) disable iff (i_rst)
		run && dec_p && !inc_p && cur_digit == 4'h0 |=> value_ff == $past(value_ff) + 16'(9 * $past(weight));
	endproperty
	a_dec_wrap: assert property (p_dec_wrap) else $error("decrement wrap wrong");

	property p_strobe_one;
		@(posedge i_clock) disable iff (i_rst)
		run |=> $countones(disp_ff[7:4] ^ {4{strobe_inv}}) <= 1;
	endproperty
	a_strobe_one: assert property (p_strobe_one) else $error("more than one strobe");

	property p_data_under_strobe;
		@(posedge i_clock) disable iff (i_rst)
		run && scan_ff == sel_ff && !inc_p && !dec_p ##1 i_ce
			|-> (disp_ff[3:0] ^ {4{data_inv}}) == $past(scan_digit);
	endproperty
	a_data_under_strobe: assert property (p_data_under_strobe) else $error("data mismatch");

	property p_once;
		@(posedge i_clock) disable iff (i_rst)
		inc_p |=> !inc_p;
	endproperty
	a_once: assert property (p_once) else $error("press repeated");

	property p_ce_freeze;
		@(posedge i_clock) disable iff (i_rst)
		!i_ce |=> $stable(value_ff) && $stable(sel_ff) && $stable(scan_ff)
			&& $stable(disp_ff) && $stable(eno_ff);
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved under low enable");

	property p_eno_follow;
		@(posedge i_clock) disable iff (i_rst)
		i_ce |=> eno_ff == $past(i_cmd_enable);
	endproperty
	a_eno_follow: assert property (p_eno_follow) else $error("state out does not follow");

	property p_off_dark;
		@(posedge i_clock) disable iff (i_rst)
		i_ce && !i_cmd_enable |=> disp_ff == {{4{strobe_inv}}, {4{data_inv}}};
	endproperty
	a_off_dark: assert property (p_off_dark) else $error("display active while off");

	property p_sel_hold;
		@(posedge i_clock) disable iff (i_rst)
		run && !down_p && !up_p |=> $stable(sel_ff);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("digit moved without press");

	property p_value_hold;
		@(posedge i_clock) disable iff (i_rst)
		run && !inc_p && !dec_p |=> $stable(value_ff);
	endproperty
	a_value_hold: assert property (p_value_hold) else $error("value moved without press");
endmodule : arrow_switch_digit_entry
`default_nettype wire

// *** core/switch_sync.sv ***
// three-stage input synchroniser with press detection
`timescale 1ns/1ps
`default_nettype none
module switch_sync #(
	parameter int WIDTH = 4
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [WIDTH-1:0] i_raw,
	output logic [WIDTH-1:0] o_level,
	output logic [WIDTH-1:0] o_press
);
	logic [WIDTH-1:0] s1_ff;
	logic [WIDTH-1:0] s2_ff;
	logic [WIDTH-1:0] s3_ff;
	logic [WIDTH-1:0] level_ff;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else if (i_ce) begin
			s1_ff <= i_raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// a change counts only when the second and third stage agree
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge i_clock or posedge i_rst) begin
				if (i_rst) begin
					level_ff[g] <= 1'b0;
				end else if (i_ce && (s2_ff[g] == s3_ff[g])) begin
					level_ff[g] <= s3_ff[g];
				end
			end
			assign o_press[g] = i_ce && (s2_ff[g] == s3_ff[g]) && s3_ff[g] && !level_ff[g];
		end
	endgenerate

	assign o_level = level_ff;
endmodule : switch_sync
`default_nettype wire

// *** sim/arrow_panel_model.sv ***
// arrow switch panel and strobed BCD display on the far side of the entry unit
`timescale 1ns/1ps
`default_nettype none
module arrow_panel_model #(
	parameter logic [1:0] POLARITY = 2'h1
) (
	input wire logic i_clock,
	input wire logic [7:0] i_display_outputs,
	output logic [3:0] o_switches
);
	logic [3:0] shown [4];
	initial begin
		o_switches = 4'h0;
		for (int k = 0; k < 4; k++) begin
			shown[k] = 4'hF;
		end
	end
	// ****************************************************************
	// display latch: a digit is loaded only while its strobe is active, then held
	// ****************************************************************
	always @(posedge i_clock) begin
		for (int k = 0; k < 4; k++) begin
			if (i_display_outputs[4 + k] !== POLARITY[0]) begin
				shown[k] <= i_display_outputs[3:0] ^ {4{POLARITY[1]}};
			end
		end
	end
	// ****************************************************************
	// switches: bit 0 inc, 1 dec, 2 move down, 3 move up
	// ****************************************************************
	// held long enough to clear the three-stage synchroniser both ways
	task automatic hold(input int k, input int n);
		@(posedge i_clock);
		o_switches[k] <= 1'b1;
		repeat (n) @(posedge i_clock);
		o_switches[k] <= 1'b0;
		repeat (4) @(posedge i_clock);
	endtask
	task automatic press(input int k);
		hold(k, 5);
	endtask
endmodule // arrow_panel_model
`default_nettype wire

// *** sim/arrow_switch_digit_entry_tb.sv ***
// self-checking bench for the arrow-switch digit entry unit
`timescale 1ns/1ps
`default_nettype none
module arrow_switch_digit_entry_tb;
	localparam logic [1:0] POL = 2'h1;
	logic i_clock;
	logic i_rst;
	logic i_ce;
	logic i_cmd_enable;
	logic [3:0] sw;
	logic [15:0] value;
	logic [7:0] disp;
	logic [1:0] sel;
	logic execution_state_out;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	int dig [4] = '{0, 0, 0, 0};
	int cur = 0;

	arrow_switch_digit_entry #(
		.POLARITY(POL)
	) u_arrow_switch_digit_entry (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_cmd_enable(i_cmd_enable),
		.i_switches(sw),
		.o_entered_value_word(value),
		.o_display_outputs(disp),
		.o_selected_digit(sel),
		.o_execution_state_out(execution_state_out)
	);
	arrow_panel_model #(
		.POLARITY(POL)
	) u_arrow_panel_model (
		.i_clock(i_clock),
		.i_display_outputs(disp),
		.o_switches(sw)
	);

	initial begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end
	// ****************************************************************
	// shared helpers
	// ****************************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [15:0] exp_value();
		return 16'(dig[0] * 1000 + dig[1] * 100 + dig[2] * 10 + dig[3]);
	endfunction
	task automatic stop_test();
		$display("checks=%0d miscompares=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset();
		check(value, 16'h0000);
		check(16'(sel), 16'h0000);
		check(16'(disp), 16'h00F0);
		check(16'(execution_state_out), 16'h0000);
	endtask
	task automatic t_move();
		for (int i = 0; i < 4; i++) begin
			u_arrow_panel_model.press(2);
			cur = (cur + 1) % 4;
			check(16'(sel), 16'(cur));
		end
		for (int i = 0; i < 4; i++) begin
			u_arrow_panel_model.press(3);
			cur = (cur + 3) % 4;
			check(16'(sel), 16'(cur));
		end
	endtask
	// wraps at both ends of a digit; the other digits must stay put
	task automatic t_edit();
		u_arrow_panel_model.press(3);
		cur = 3;
		for (int i = 0; i < 10; i++) begin
			u_arrow_panel_model.press(0);
			dig[3] = (dig[3] + 1) % 10;
			check(value, exp_value());
		end
		u_arrow_panel_model.press(3);
		cur = 2;
		u_arrow_panel_model.press(1);
		dig[2] = 9;
		check(value, exp_value());
		u_arrow_panel_model.press(2);
		u_arrow_panel_model.press(2);
		cur = 0;
		for (int i = 0; i < 11; i++) begin
			u_arrow_panel_model.press(1);
			dig[0] = (dig[0] + 9) % 10;
			check(value, exp_value());
		end
	endtask
	task automatic t_hold();
		u_arrow_panel_model.hold(0, 30);
		dig[cur] = (dig[cur] + 1) % 10;
		check(value, exp_value());
	endtask
	task automatic t_display();
		repeat (8) @(posedge i_clock);
		#1;
		check(16'(u_arrow_panel_model.shown[cur]), 16'(dig[cur]));
	endtask
	task automatic t_cmd_off();
		i_cmd_enable <= 1'b0;
		repeat (3) @(posedge i_clock);
		#1;
		check(16'(execution_state_out), 16'h0000);
		check(16'(disp[7:4]), 16'h000F);
		u_arrow_panel_model.press(0);
		u_arrow_panel_model.press(2);
		check(value, exp_value());
		check(16'(sel), 16'(cur));
		i_cmd_enable <= 1'b1;
		repeat (2) @(posedge i_clock);
		#1;
		check(16'(execution_state_out), 16'h0001);
	endtask

	// a low clock enable must swallow presses and hold the display still
	task automatic t_freeze();
		logic [7:0] held;
		@(posedge i_clock);
		i_ce <= 1'b0;
		#1;
		held = disp;
		u_arrow_panel_model.press(0);
		u_arrow_panel_model.press(3);
		check(16'(disp), 16'(held));
		check(16'(execution_state_out), 16'h0001);
		i_ce <= 1'b1;
		repeat (4) @(posedge i_clock);
		#1;
		check(value, exp_value());
		check(16'(sel), 16'(cur));
	endtask
	task automatic t_reset_mid();
		@(posedge i_clock);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		#1;
		t_reset();
		dig = '{0, 0, 0, 0};
		cur = 0;
	endtask

	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			stop_test();
		end
	end

	initial begin
		i_rst = 1'b1;
		i_ce = 1'b1;
		i_cmd_enable = 1'b1;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		#1;
		t_reset();
		t_move();
		t_edit();
		t_hold();
		t_display();
		t_cmd_off();
		t_freeze();
		t_display();
		t_reset_mid();
		t_display();
		stop_test();
	end
endmodule // arrow_switch_digit_entry_tb
`default_nettype wire
